// file: rwd_timer.sv
// Runaway watchdog timer with its key register and clock mode settings.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Twenty-two stage counter advances every second cycle.
// RULE2: Period field picks one of four overflow taps.
// RULE3: Period field resets to shortest period.
// RULE4: Enable bit resets to one.
// RULE5: Disable needs enable cleared then disable key.
// RULE6: Setting enable bit alone re-enables.
// RULE7: Clear key zeroes counter; counting resumes.
// RULE8: Reset connect bit resets to zero.
// RULE9: Internal reset pulse lasts 44 to 58 cycles.
// RULE10: Overflow raises non-maskable interrupt.
// RULE11: Software clears counter before each period ends.
// RULE12: Counting starts right after reset release.
// RULE13: Light idle and stop reset and halt counter.
// RULE14: Counting continues during bus release.
// RULE15: Deep idle run bit decides counting there.
// RULE16: Warm bit selects 2^5 or 2^17 settle.
// RULE17: Clock pin gives fc or 2/5 fc, gated; the fast setting here gives fc/2, half the system clock rate.
// RULE18: Halt field selects deep, light idle or stop.
// RULE19: Other key values change nothing.
// RULE20: Disable key ignored unless enable already zero.
module rwd_timer #(
  parameter int WARM_LONG = rwd_pkg::WARM_LONG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic halt_req,
  input wire logic stop_wake,
  input wire logic bus_release_ack_n,
  output logic runaway_nmi,
  output logic wd_reset_out,
  output logic clk_pin_out,
  output logic deep_idle_state,
  output logic light_idle_state,
  output logic stop_state,
  output logic warm_up_busy
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic wd_enable_bit;
  logic [1:0] detect_period_sel;
  logic deep_idle_run_bit;
  logic overflow_reset_connect;
  logic active;
  logic [7:0] clock_mode_reg;
  logic [21:0] count;
  logic prescale;
  logic [5:0] reset_count;
  logic [17:0] warm_count;
  logic [1:0] low_power;
  logic overflow;
  logic tap_bit;
  logic tap_prev;
  logic halt_counter;

  wire logic wr_mode = wr_stb && (addr == rwd_pkg::ADDR_WD_MODE);
  wire logic wr_key = wr_stb && (addr == rwd_pkg::ADDR_WD_KEY);
  wire logic wr_clk = wr_stb && (addr == rwd_pkg::ADDR_CLOCK_MODE);

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      detect_period_sel <= rwd_pkg::PERIOD_RESET; // [RULE3]
      wd_enable_bit <= rwd_pkg::ENABLE_RESET; // [RULE4]
      overflow_reset_connect <= rwd_pkg::RESET_CONNECT_RESET; // [RULE8]
      deep_idle_run_bit <= 1'b0;
    end else if (clk_en && wr_mode) begin
      wd_enable_bit <= wdata[rwd_pkg::MODE_ENABLE_BIT];
      detect_period_sel <= wdata[rwd_pkg::MODE_PERIOD_HI:rwd_pkg::MODE_PERIOD_LO];
      overflow_reset_connect <= wdata[rwd_pkg::MODE_RESET_CONNECT_BIT];
      deep_idle_run_bit <= wdata[rwd_pkg::MODE_DEEP_IDLE_BIT]; // [RULE15]
    end
  end

  // ----------------------------------------------------------------
  // Run state: disabled only by the two-step key sequence
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active <= 1'b1; // [RULE4]
    end else if (clk_en) begin
      if (wr_mode && wdata[rwd_pkg::MODE_ENABLE_BIT]) begin
        active <= 1'b1; // [RULE6]
      end else if (wr_key && wdata == rwd_pkg::KEY_DISABLE && !wd_enable_bit) begin
        active <= 1'b0; // [RULE5] [RULE19] [RULE20]
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock mode register and low-power state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clock_mode_reg <= rwd_pkg::CLOCK_MODE_RESET;
    end else if (clk_en && wr_clk) begin
      clock_mode_reg <= wdata;
    end
  end

  // A halt request enters the state named by the halt field; a wake ends it. [RULE18]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      low_power <= 2'(rwd_pkg::RWD_HALT_NONE);
    end else if (clk_en) begin
      if (stop_wake) begin
        low_power <= 2'(rwd_pkg::RWD_HALT_NONE);
      end else if (halt_req && low_power == 2'(rwd_pkg::RWD_HALT_NONE)) begin
        low_power <= clock_mode_reg[rwd_pkg::CLK_HALT_HI:rwd_pkg::CLK_HALT_LO];
      end
    end
  end

  assign deep_idle_state = (low_power == 2'(rwd_pkg::RWD_HALT_DEEP_IDLE));
  assign light_idle_state = (low_power == 2'(rwd_pkg::RWD_HALT_LIGHT_IDLE));
  assign stop_state = (low_power == 2'(rwd_pkg::RWD_HALT_STOP));

  // Warm-up after stop: a long settle is a parameter so simulation can shorten it. [RULE16]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      warm_count <= 18'h0;
    end else if (clk_en) begin
      if (stop_state && stop_wake) begin
        warm_count <= clock_mode_reg[rwd_pkg::CLK_WARM_BIT] ? 18'(WARM_LONG)
                                                           : 18'(rwd_pkg::WARM_SHORT_CYCLES);
      end else if (warm_count != 18'h0) begin
        warm_count <= warm_count - 18'h1;
      end
    end
  end

  assign warm_up_busy = (warm_count != 18'h0);

  // ----------------------------------------------------------------
  // Binary counter
  // ----------------------------------------------------------------
  // Light idle and stop hold it at zero; deep idle obeys its run bit. [RULE13] [RULE15]
  // Bus release is deliberately not an input to this term. [RULE14]
  assign halt_counter = light_idle_state || stop_state
                        || (deep_idle_state && !deep_idle_run_bit);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count <= 22'h0; // [RULE12]
      prescale <= 1'b0;
    end else if (clk_en) begin
      if (halt_counter || (wr_key && wdata == rwd_pkg::KEY_CLEAR)) begin
        count <= 22'h0; // [RULE7] [RULE13]
        prescale <= 1'b0;
      end else if (active) begin
        prescale <= ~prescale;
        if (prescale) begin
          count <= count + 22'h1; // [RULE1]
        end
      end
    end
  end

  // Overflow is the falling edge of the selected tap. [RULE2]
  always_comb begin
    tap_bit = count[rwd_pkg::PERIOD_SHIFT_BASE + 2 * int'(detect_period_sel)];
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tap_prev <= 1'b0;
    end else if (clk_en) begin
      // A clear, a halt or a new period would fake a falling tap, so the history restarts.
      if (halt_counter || wr_mode || (wr_key && wdata == rwd_pkg::KEY_CLEAR)) begin
        tap_prev <= 1'b0; // [RULE7]
      end else begin
        tap_prev <= tap_bit;
      end
    end
  end

  assign overflow = tap_prev && !tap_bit && active && !halt_counter;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      runaway_nmi <= 1'b0;
    end else if (clk_en) begin
      runaway_nmi <= overflow; // [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // Internal reset pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reset_count <= 6'h0;
    end else if (clk_en) begin
      if (overflow && overflow_reset_connect) begin
        reset_count <= 6'(rwd_pkg::RESET_PULSE_CYCLES); // [RULE9]
      end else if (reset_count != 6'h0) begin
        reset_count <= reset_count - 6'h1;
      end
    end
  end

  assign wd_reset_out = (reset_count != 6'h0);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (clk_en && rd_stb) begin
      unique case (addr)
        rwd_pkg::ADDR_WD_MODE: rdata <= {wd_enable_bit, detect_period_sel, 2'h0,
                                         deep_idle_run_bit, overflow_reset_connect, 1'b0};
        rwd_pkg::ADDR_WD_KEY: rdata <= 8'h00;
        rwd_pkg::ADDR_CLOCK_MODE: rdata <= clock_mode_reg;
        rwd_pkg::ADDR_STATUS: rdata <= {5'h0, warm_up_busy, wd_reset_out, active};
      endcase
    end
  end

  // The clock pin keeps running in all states; gating is software's choice. [RULE17]
  rwd_clk_div u_clk_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .out_en(clock_mode_reg[rwd_pkg::CLK_OUT_EN_BIT]),
    .slow_sel(clock_mode_reg[rwd_pkg::CLK_SOURCE_BIT]),
    .pin_out(clk_pin_out)
  );

  wire logic unused_bus_ack = bus_release_ack_n;

endmodule

`default_nettype wire

// file: rwd_pkg.sv
// Package with register map, field layout, reset values and timing counts of the runaway timer.
package rwd_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_WD_MODE = 2'h0;
  localparam logic [1:0] ADDR_WD_KEY = 2'h1;
  localparam logic [1:0] ADDR_CLOCK_MODE = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_PERIOD_HI = 6;
  localparam int MODE_PERIOD_LO = 5;
  localparam int MODE_DEEP_IDLE_BIT = 2;
  localparam int MODE_RESET_CONNECT_BIT = 1;

  // ----------------------------------------------------------------
  // Clock mode register fields
  // ----------------------------------------------------------------
  localparam int CLK_WARM_BIT = 5;
  localparam int CLK_HALT_HI = 3;
  localparam int CLK_HALT_LO = 2;
  localparam int CLK_SOURCE_BIT = 1;
  localparam int CLK_OUT_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------
  localparam logic [1:0] PERIOD_RESET = 2'h0;
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic RESET_CONNECT_RESET = 1'b0;
  localparam logic [7:0] KEY_DISABLE = 8'hB1;
  localparam logic [7:0] KEY_CLEAR = 8'h4E;
  localparam logic [7:0] CLOCK_MODE_RESET = 8'h01;

  // ----------------------------------------------------------------
  // Counter and timing
  // ----------------------------------------------------------------
  localparam int COUNTER_STAGES = 22;
  localparam int PERIOD_SHIFT_BASE = 14;
  localparam int RESET_PULSE_MIN = 44;
  localparam int RESET_PULSE_MAX = 58;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_MIN + RESET_PULSE_MAX) / 2;
  localparam int WARM_SHORT_EXP = 5;
  localparam int WARM_LONG_EXP = 17;
  localparam int WARM_SHORT_CYCLES = 1 << WARM_SHORT_EXP;
  localparam int WARM_LONG_CYCLES = 1 << WARM_LONG_EXP;

  typedef enum logic [1:0] {
    RWD_HALT_DEEP_IDLE,
    RWD_HALT_LIGHT_IDLE,
    RWD_HALT_STOP,
    RWD_HALT_NONE
  } rwd_halt_t;

endpackage

// file: rwd_clk_div.sv
// Clock pin generator: gives half the system clock rate or a two-in-five rate.
`timescale 1ns/1ps
`default_nettype none

module rwd_clk_div (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic out_en,
  input wire logic slow_sel,
  output logic pin_out
);

  // ----------------------------------------------------------------
  // Five-step phase counter
  // ----------------------------------------------------------------
  logic [2:0] phase;
  logic fast_level;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase <= 3'h0;
      fast_level <= 1'b0;
    end else if (clk_en) begin
      phase <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
      fast_level <= ~fast_level;
    end
  end

  // Two high pulses in every five steps give the 2/5 rate. [RULE17]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_out <= 1'b0;
    end else if (clk_en) begin
      if (!out_en) begin
        pin_out <= 1'b0;
      end else if (slow_sel) begin
        pin_out <= (phase == 3'h0) || (phase == 3'h2);
      end else begin
        pin_out <= fast_level;
      end
    end
  end

endmodule

`default_nettype wire

// file: rwd_timer_props.sv
// Concurrent checks on the ports of the runaway timer.
`timescale 1ns/1ps
`default_nettype none
module rwd_timer_props #(
  parameter int WARM_LONG = rwd_pkg::WARM_LONG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] addr,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic stop_wake,
  input wire logic runaway_nmi,
  input wire logic wd_reset_out,
  input wire logic deep_idle_state,
  input wire logic light_idle_state,
  input wire logic stop_state,
  input wire logic warm_up_busy
);
  int unsigned rst_len;
  int unsigned warm_len;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // Pulse length counters
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst || !wd_reset_out) rst_len <= 0;
    else rst_len <= rst_len + 1;
  end
  always_ff @(posedge sys_clk) begin
    if (srst || !warm_up_busy) warm_len <= 0;
    else warm_len <= warm_len + 1;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_nmi_pulse;
    runaway_nmi |=> !runaway_nmi;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi longer than one cycle");
  property p_rst_len;
    $fell(wd_reset_out) && !$past(srst) |-> rst_len >= 44 && rst_len <= 58;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
  property p_rst_max;
    rst_len <= 58;
  endproperty
  a_rst_max: assert property (p_rst_max) else $error("reset pulse too long");
  property p_key_read;
    rd_stb && addr == rwd_pkg::ADDR_WD_KEY |=> rdata == 8'h00;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key register not zero");
  property p_after_rst;
    $fell(srst) |-> !runaway_nmi && !wd_reset_out;
  endproperty
  a_after_rst: assert property (p_after_rst) else $error("outputs busy after reset");
  property p_states;
    $onehot0({deep_idle_state, light_idle_state, stop_state});
  endproperty
  a_states: assert property (p_states) else $error("two halt states at once");
  property p_wake;
    stop_wake && (deep_idle_state || light_idle_state) |=> !deep_idle_state && !light_idle_state;
  endproperty
  a_wake: assert property (p_wake) else $error("idle state kept after wake");
  property p_halt_quiet;
    (light_idle_state || stop_state) && $past(light_idle_state || stop_state) |-> !runaway_nmi;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("nmi while halted");
  property p_warm_cause;
    $rose(warm_up_busy) |-> $past(stop_state);
  endproperty
  a_warm_cause: assert property (p_warm_cause) else $error("warm-up not from stop");
  property p_warm_len;
    warm_len <= WARM_LONG;
  endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm-up too long");
endmodule
bind rwd_timer rwd_timer_props #(.WARM_LONG(WARM_LONG)) u_props (.sys_clk(sys_clk),
  .srst(srst), .addr(addr), .rd_stb(rd_stb), .rdata(rdata), .stop_wake(stop_wake),
  .runaway_nmi(runaway_nmi), .wd_reset_out(wd_reset_out), .deep_idle_state(deep_idle_state),
  .light_idle_state(light_idle_state), .stop_state(stop_state), .warm_up_busy(warm_up_busy));
`default_nettype wire

// file: rwd_timer_tb.sv
// Self-checking bench for the runaway timer.
`timescale 1ns/1ps
`default_nettype none
module rwd_timer_tb;
  localparam int WL = 64;
  localparam int P = 1 << 16;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic halt_req = 1'b0;
  logic stop_wake = 1'b0;
  logic bus_release_ack_n = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] rdata;
  logic runaway_nmi, wd_reset_out, clk_pin_out;
  logic deep_idle_state, light_idle_state, stop_state, warm_up_busy;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 95249;
  int n_nmi = 0;
  int m_act = 1;
  logic [7:0] m_mode = 8'h80;
  logic [7:0] m_clk = 8'h01;
  int n, r, w;
  int tg[3];
  always #50 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (runaway_nmi === 1'b1) n_nmi++;
  rwd_timer #(.WARM_LONG(WL)) dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .halt_req(halt_req), .stop_wake(stop_wake), .bus_release_ack_n(bus_release_ack_n),
    .runaway_nmi(runaway_nmi), .wd_reset_out(wd_reset_out), .clk_pin_out(clk_pin_out),
    .deep_idle_state(deep_idle_state), .light_idle_state(light_idle_state),
    .stop_state(stop_state), .warm_up_busy(warm_up_busy));
  // ------------------------------------------------------------
  // Bus tasks and reference model
  // ------------------------------------------------------------
  task automatic chk(input logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t mismatch", $time);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    if (a == rwd_pkg::ADDR_WD_MODE) m_mode = d;
    if (a == rwd_pkg::ADDR_WD_MODE && d[7]) m_act = 1;
    if (a == rwd_pkg::ADDR_WD_KEY && d == rwd_pkg::KEY_DISABLE && !m_mode[7]) m_act = 0;
    if (a == rwd_pkg::ADDR_CLOCK_MODE) m_clk = d;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 chk((rdata & m) === (e & m));
    @(posedge sys_clk);
  endtask
  task automatic stat;
    rd(rwd_pkg::ADDR_STATUS, {7'h00, m_act[0]}, 8'h01);
  endtask
  // Stop wake is always sent, so no state is left behind for the next case.
  task automatic halt(input logic [1:0] hs, input logic wm);
    wr(rwd_pkg::ADDR_CLOCK_MODE, {2'h0, wm, 1'b0, hs, 2'h1});
    rd(rwd_pkg::ADDR_CLOCK_MODE, m_clk, 8'h2F);
    halt_req <= 1'b1;
    @(posedge sys_clk);
    halt_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk({deep_idle_state, light_idle_state, stop_state} === (3'h4 >> hs));
    @(posedge sys_clk);
    stop_wake <= 1'b1;
    @(posedge sys_clk);
    stop_wake <= 1'b0;
    n = 0;
    repeat (200) @(negedge sys_clk) if (warm_up_busy === 1'b1) n++;
    chk(n == (hs == 2'h2 ? (wm ? WL : 32) : 0));
    @(posedge sys_clk);
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(rwd_pkg::ADDR_WD_MODE, 8'h80, 8'hE6);
    rd(rwd_pkg::ADDR_CLOCK_MODE, rwd_pkg::CLOCK_MODE_RESET, 8'h2F);
    stat();
    for (int p = 0; p < 4; p++) begin
      wr(rwd_pkg::ADDR_WD_MODE, {1'b1, p[1:0], 5'h00});
      rd(rwd_pkg::ADDR_WD_MODE, m_mode, 8'hE6);
    end
    wr(rwd_pkg::ADDR_WD_KEY, rwd_pkg::KEY_DISABLE);
    stat();
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      if (r[7:0] == rwd_pkg::KEY_DISABLE || r[7:0] == rwd_pkg::KEY_CLEAR) r = 0;
      if (i == 3) wr(rwd_pkg::ADDR_WD_MODE, 8'h00);
      wr(rwd_pkg::ADDR_WD_KEY, r[7:0]);
      stat();
    end
    rd(rwd_pkg::ADDR_WD_KEY, 8'h00, 8'hFF);
    wr(rwd_pkg::ADDR_WD_KEY, rwd_pkg::KEY_DISABLE);
    stat();
    wr(rwd_pkg::ADDR_WD_MODE, 8'h80);
    stat();
    for (int h = 0; h < 4; h++) halt(h[1:0], 1'b0);
    halt(2'h2, 1'b1);
    for (int c = 0; c < 3; c++) begin
      wr(rwd_pkg::ADDR_CLOCK_MODE, (c == 0) ? 8'h00 : ((c == 1) ? 8'h01 : 8'h03));
      tg[c] = 0;
      w = clk_pin_out;
      repeat (50) @(negedge sys_clk) begin
        if (clk_pin_out !== w[0]) tg[c]++;
        w = clk_pin_out;
      end
      @(posedge sys_clk);
    end
    chk(tg[0] == 0 && tg[1] > 0 && tg[2] > 0 && tg[1] != tg[2]);
    clk_en <= 1'b0;
    n = 0;
    @(negedge sys_clk);
    w = clk_pin_out;
    repeat (20) @(negedge sys_clk) if (clk_pin_out !== w[0]) n++;
    @(posedge sys_clk);
    clk_en <= 1'b1;
    chk(n == 0);
    wr(rwd_pkg::ADDR_WD_MODE, 8'h82);
    repeat (2) begin
      wr(rwd_pkg::ADDR_WD_KEY, rwd_pkg::KEY_CLEAR);
      repeat (15000) begin
        @(posedge sys_clk);
        r = $random(seed);
        bus_release_ack_n <= r[0];
      end
    end
    chk(n_nmi == 0);
    halt(2'h1, 1'b0);
    n = 0;
    while (n_nmi == 0 && n < 70000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n > P - 220 && n < P - 180);
    w = 0;
    repeat (100) @(negedge sys_clk) if (wd_reset_out === 1'b1) w++;
    chk(w >= 44 && w <= 58);
    results();
  end
endmodule
`default_nettype wire
